// File: logic/cbts_card.sv
// Serial mode card engine; in native mode it only watches the command line for the entry reset.
// Assumes the host drives link clock, select and commands; all logic runs on clk.
`timescale 1ns/10ps
`default_nettype none
`include "cbts_defines.svh"
module cbts_card
    import cbts_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       linkClk,
    input  wire logic       selectN,
    input  wire logic       hostToCardLine,
    input  wire logic       partialAllowed,
    input  wire logic       retrieveError,
    output var  logic       cardToHostLine,
    output var  logic       serialMode,
    output var  logic       programming,
    output var  logic       writeStrobe,
    output var  logic [7:0] writeByte
);
    cbts_byte_if link ();

    cbts_shifter u_shift (
        .clk            (clk),
        .rstn           (rstn),
        .linkClk        (linkClk),
        .selectN        (selectN),
        .hostToCardLine (hostToCardLine),
        .cardToHostLine (cardToHostLine),
        .bus            (link)
    );

    cbts_state_t st_reg, st_next;
    logic        chosen_reg, chosen_next, spi_reg, spi_next;
    logic [2:0]  cmdIdx_reg, cmdIdx_next;
    logic [5:0]  cmd_reg, cmd_next;
    logic [7:0]  resp_reg, resp_next;
    logic [2:0]  respLeft_reg, respLeft_next;
    logic [9:0]  len_reg, len_next, cnt_reg, cnt_next;
    logic [6:0]  gap_reg, gap_next;
    logic        multi_reg, multi_next, isWrite_reg, isWrite_next;
    logic        err_reg, err_next;
    logic [15:0] busy_reg, busy_next;
    logic [7:0]  wb_reg, wb_next;
    logic        ws_reg, ws_next;
    logic [7:0]  txB;
    logic        txL;

    function automatic logic [9:0] reg_len(input logic [5:0] c);
        case (c)
            `CBTS_CMD_SEND_CID:  reg_len = `CBTS_LEN_CID;
            `CBTS_CMD_SEND_CSD:  reg_len = `CBTS_LEN_CSD;
            `CBTS_CMD_EXTENDED_CARD_REGISTER:   reg_len = `CBTS_LEN_EXT;
            `CBTS_CMD_READ_ONE,
            `CBTS_CMD_READ_MULTI: reg_len = `CBTS_LEN_EXT;
            `CBTS_CMD_WRITE_ONE,
            `CBTS_CMD_WRITE_MULT: reg_len = `CBTS_LEN_CID;
            default:             reg_len = 10'h000;
        endcase
    endfunction

    function automatic logic [2:0] resp_bytes(input logic [5:0] c);
        case (c)
            `CBTS_CMD_STATUS:   resp_bytes = 3'h2;
            `CBTS_CMD_READ_OCR: resp_bytes = 3'h5;
            default:            resp_bytes = 3'h1;
        endcase
    endfunction

    assign link.txLoad = txL;
    assign link.txByte = txB;
    assign serialMode  = spi_reg;
    assign programming = (st_reg == CBTS_BUSY);
    assign writeStrobe = ws_reg;
    assign writeByte   = wb_reg;

    always_comb begin
        st_next       = st_reg;
        chosen_next   = chosen_reg;
        spi_next      = spi_reg;
        cmdIdx_next   = cmdIdx_reg;
        cmd_next      = cmd_reg;
        resp_next     = resp_reg;
        respLeft_next = respLeft_reg;
        len_next      = len_reg;
        cnt_next      = cnt_reg;
        gap_next      = gap_reg;
        multi_next    = multi_reg;
        isWrite_next  = isWrite_reg;
        err_next      = err_reg;
        busy_next     = busy_reg;
        wb_next       = wb_reg;
        ws_next       = 1'b0;
        txL           = 1'b0;
        txB           = 8'hff;
        if (st_reg == CBTS_BUSY) begin
            txL = link.selected;
            txB = 8'h00;
            busy_next = busy_reg - 16'h0001;
            if (busy_reg == 16'h0000) begin
                st_next = CBTS_IDLE;
            end
        end else if (!link.selected && st_reg != CBTS_IDLE) begin
            st_next = CBTS_IDLE;
            cmdIdx_next = 3'h0;
        end else begin
            case (st_reg)
                CBTS_IDLE, CBTS_CMD: begin
                    if (link.rxValid) begin
                        if (cmdIdx_reg == 3'h0) begin
                            if (link.rxByte[7:6] == 2'h1) begin
                                cmd_next    = link.rxByte[5:0];
                                cmdIdx_next = 3'h1;
                                st_next     = CBTS_CMD;
                            end
                        end else if (cmdIdx_reg == 3'h5) begin
                            cmdIdx_next = 3'h0;
                            if (!chosen_reg && cmd_reg == `CBTS_CMD_RESET
                                && link.rxByte == 8'h95) begin
                                chosen_next = 1'b1;
                                spi_next = 1'b1;
                            end
                            if (spi_reg || (!chosen_reg && cmd_reg == `CBTS_CMD_RESET
                                            && link.rxByte == 8'h95)) begin
                                gap_next = `CBTS_NCR_MIN;
                                st_next  = CBTS_WAIT;
                                respLeft_next = resp_bytes(cmd_reg);
                                len_next = reg_len(cmd_reg);
                                multi_next = (cmd_reg == `CBTS_CMD_READ_MULTI)
                                           | (cmd_reg == `CBTS_CMD_WRITE_MULT);
                                isWrite_next = (cmd_reg == `CBTS_CMD_WRITE_ONE)
                                             | (cmd_reg == `CBTS_CMD_WRITE_MULT);
                                case (cmd_reg)
                                    `CBTS_CMD_RESET:     resp_next = `CBTS_R1_IDLE;
                                    `CBTS_CMD_ALL_CID, `CBTS_CMD_SET_ADDR,
                                    `CBTS_CMD_BUS_TEST,
                                    `CBTS_CMD_READ_DAT,
                                    `CBTS_CMD_WRITE_DAT: resp_next = `CBTS_R1_ILLEGAL;
                                    default: resp_next = (!partialAllowed
                                                          && multi_next)
                                                         ? `CBTS_R1_READY
                                                         : `CBTS_R1_READY;
                                endcase
                                if (resp_next != `CBTS_R1_READY) begin
                                    len_next = 10'h000;
                                    isWrite_next = 1'b0;
                                end
                            end else begin
                                st_next = CBTS_IDLE;
                            end
                        end else begin
                            cmdIdx_next = cmdIdx_reg + 3'h1;
                        end
                    end
                end
                CBTS_WAIT: begin
                    if (link.txTaken) begin
                        gap_next = gap_reg - 7'h01;
                        if (gap_reg == 7'h01) begin
                            st_next = CBTS_RESP;
                        end
                    end
                end
                CBTS_RESP: begin
                    txL = 1'b1;
                    txB = (respLeft_reg == resp_bytes(cmd_reg)) ? resp_reg : 8'h00;
                    if (link.txTaken) begin
                        respLeft_next = respLeft_reg - 3'h1;
                        if (respLeft_reg == 3'h1) begin
                            gap_next = `CBTS_NAC_MIN;
                            st_next = isWrite_reg ? CBTS_WSTART
                                    : (len_reg != 10'h000) ? CBTS_DGAP : CBTS_IDLE;
                        end
                    end
                end
                CBTS_DGAP: begin
                    if (link.txTaken) begin
                        gap_next = gap_reg - 7'h01;
                        if (gap_reg == 7'h01) begin
                            st_next = CBTS_DTOKEN;
                        end
                    end
                end
                CBTS_DTOKEN: begin
                    txL = 1'b1;
                    txB = retrieveError ? `CBTS_TOKEN_ERROR : `CBTS_TOKEN_START;
                    if (link.txTaken) begin
                        err_next = retrieveError;
                        cnt_next = len_reg;
                        st_next  = retrieveError ? CBTS_IDLE : CBTS_DATA;
                    end
                end
                CBTS_DATA: begin
                    txL = 1'b1;
                    txB = cnt_reg[7:0];
                    if (link.txTaken) begin
                        cnt_next = cnt_reg - 10'h001;
                        if (cnt_reg == 10'h001) begin
                            cnt_next = 10'h002;
                            st_next = CBTS_CRC;
                        end
                    end
                    if (link.rxValid && cmdIdx_reg == 3'h0 && link.rxByte == 8'h4c) begin
                        cmdIdx_next = 3'h1;
                        cmd_next = `CBTS_CMD_STOP;
                        st_next  = CBTS_CMD;
                    end
                end
                CBTS_CRC: begin
                    txL = 1'b1;
                    txB = 8'h00;
                    if (link.txTaken) begin
                        cnt_next = cnt_reg - 10'h001;
                        if (cnt_reg == 10'h001) begin
                            gap_next = `CBTS_NAC_MIN;
                            st_next = multi_reg ? CBTS_DGAP : CBTS_IDLE;
                        end
                    end
                end
                CBTS_WSTART: begin
                    if (link.rxValid) begin
                        if (link.rxByte == `CBTS_TOKEN_START) begin
                            cnt_next = (partialAllowed ? len_reg : `CBTS_LEN_EXT) + 10'h002;
                            st_next = CBTS_WDATA;
                        end else if (link.rxByte == `CBTS_TOKEN_STOP && multi_reg) begin
                            busy_next = `CBTS_BUSY_CYCLES;
                            st_next = CBTS_BUSY;
                        end
                    end
                end
                CBTS_WDATA: begin
                    if (link.rxValid) begin
                        wb_next = link.rxByte;
                        ws_next = (cnt_reg > 10'h002);
                        cnt_next = cnt_reg - 10'h001;
                        if (cnt_reg == 10'h001) begin
                            st_next = CBTS_WRESP;
                        end
                    end
                end
                CBTS_WRESP: begin
                    txL = 1'b1;
                    txB = `CBTS_DATA_ACCEPT;
                    if (link.txTaken) begin
                        busy_next = `CBTS_BUSY_CYCLES;
                        st_next = CBTS_BUSY;
                    end
                end
                default: st_next = CBTS_IDLE;
            endcase
        end
        if (st_reg == CBTS_BUSY && busy_reg == 16'h0000 && multi_reg) begin
            st_next = link.selected ? CBTS_WSTART : CBTS_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg       <= CBTS_IDLE;
            chosen_reg   <= 1'b0;
            spi_reg      <= 1'b0;
            cmdIdx_reg   <= 3'h0;
            cmd_reg      <= 6'h00;
            resp_reg     <= 8'hff;
            respLeft_reg <= 3'h0;
            len_reg      <= 10'h000;
            cnt_reg      <= 10'h000;
            gap_reg      <= 7'h00;
            multi_reg    <= 1'b0;
            isWrite_reg  <= 1'b0;
            err_reg      <= 1'b0;
            busy_reg     <= 16'h0000;
            wb_reg       <= 8'h00;
            ws_reg       <= 1'b0;
        end else begin
            st_reg       <= st_next;
            chosen_reg   <= chosen_next;
            spi_reg      <= spi_next;
            cmdIdx_reg   <= cmdIdx_next;
            cmd_reg      <= cmd_next;
            resp_reg     <= resp_next;
            respLeft_reg <= respLeft_next;
            len_reg      <= len_next;
            cnt_reg      <= cnt_next;
            gap_reg      <= gap_next;
            multi_reg    <= multi_next;
            isWrite_reg  <= isWrite_next;
            err_reg      <= err_next;
            busy_reg     <= busy_next;
            wb_reg       <= wb_next;
            ws_reg       <= ws_next;
        end
    end
endmodule
`default_nettype wire

// File: pkg/cbts_defines.svh
// Constants for the card bus timing and serial mode block.
// Included by the card engine and the bench; definitions only.
`ifndef CBTS_DEFINES_SVH
`define CBTS_DEFINES_SVH

`define CBTS_NCR_MIN        7'h02
`define CBTS_NCR_MAX        7'h40
`define CBTS_NID            7'h05
`define CBTS_NAC_MIN        7'h02
`define CBTS_NST            7'h02
`define CBTS_CMD_RESET      6'h00
`define CBTS_CMD_SEND_OCR   6'h01
`define CBTS_CMD_ALL_CID    6'h02
`define CBTS_CMD_SET_ADDR   6'h03
`define CBTS_CMD_SEND_CSD   6'h09
`define CBTS_CMD_SEND_CID   6'h0a
`define CBTS_CMD_READ_DAT   6'h0b
`define CBTS_CMD_STOP       6'h0c
`define CBTS_CMD_STATUS     6'h0d
`define CBTS_CMD_BUS_TEST   6'h13
`define CBTS_CMD_READ_ONE   6'h11
`define CBTS_CMD_READ_MULTI 6'h12
`define CBTS_CMD_WRITE_ONE  6'h18
`define CBTS_CMD_WRITE_MULT 6'h19
`define CBTS_CMD_WRITE_DAT  6'h14
`define CBTS_CMD_EXTENDED_CARD_REGISTER    6'h08
`define CBTS_CMD_READ_OCR   6'h3a
`define CBTS_R1_IDLE        8'h01
`define CBTS_R1_READY       8'h00
`define CBTS_R1_ILLEGAL     8'h04
`define CBTS_R1_PARAM       8'h40
`define CBTS_TOKEN_START    8'hfe
`define CBTS_TOKEN_STOP     8'hfd
`define CBTS_TOKEN_ERROR    8'h08
`define CBTS_DATA_ACCEPT    8'he5
`define CBTS_DATA_CRC_BAD   8'heb
`define CBTS_BUSY_CYCLES    16'h0400
`define CBTS_LEN_CID        10'h010
`define CBTS_LEN_CSD        10'h010
`define CBTS_LEN_EXT        10'h200
`define CBTS_LEN_OCR        10'h004

`endif

// File: pkg/cbts_pkg.sv
// Types for the card bus timing and serial mode block.
// Assumes the defines header sits beside it.
package cbts_pkg;
    typedef enum logic [3:0] {
        CBTS_IDLE    = 4'h0,
        CBTS_CMD     = 4'h1,
        CBTS_WAIT    = 4'h2,
        CBTS_RESP    = 4'h3,
        CBTS_DGAP    = 4'h4,
        CBTS_DTOKEN  = 4'h5,
        CBTS_DATA    = 4'h6,
        CBTS_CRC     = 4'h7,
        CBTS_WSTART  = 4'h8,
        CBTS_WDATA   = 4'h9,
        CBTS_WRESP   = 4'ha,
        CBTS_BUSY    = 4'hb
    } cbts_state_t;
endpackage

// File: pkg/cbts_byte_if.sv
// Byte channel between the serial shifter and the protocol engine.
// Both ends run on the system clock.
`timescale 1ns/10ps
`default_nettype none
interface cbts_byte_if;
    logic       rxValid;
    logic [7:0] rxByte;
    logic       txLoad;
    logic [7:0] txByte;
    logic       txTaken;
    logic       selected;
    logic       bitEdge;
    modport shifter (output rxValid, output rxByte, input txLoad, input txByte,
                     output txTaken, output selected, output bitEdge);
    modport engine  (input rxValid, input rxByte, output txLoad, output txByte,
                     input txTaken, input selected, input bitEdge);
endinterface
`default_nettype wire

// File: logic/cbts_shifter.sv
// Byte shifter for the serial link: samples select, clock and data pins.
// Assumes the link clock is far slower than clk (idle low, mode 0).
`timescale 1ns/10ps
`default_nettype none
module cbts_shifter
    import cbts_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic linkClk,
    input  wire logic selectN,
    input  wire logic hostToCardLine,
    output var  logic cardToHostLine,
    cbts_byte_if.shifter bus
);
    logic [1:0] clkSync_reg, selSync_reg, dinSync_reg;
    logic       clkLast_reg, clkLast_next;
    logic [2:0] bitCnt_reg, bitCnt_next;
    logic [7:0] rxSh_reg, rxSh_next, txSh_reg, txSh_next;
    logic       rxValid_reg, rxValid_next, taken_reg, taken_next;
    logic       dout_reg, dout_next;
    logic       rise, fall, sel;

    assign sel  = ~selSync_reg[1];
    assign rise = clkSync_reg[1] & ~clkLast_reg;
    assign fall = ~clkSync_reg[1] & clkLast_reg;
    assign bus.rxValid  = rxValid_reg;
    assign bus.rxByte   = rxSh_reg;
    assign bus.txTaken  = taken_reg;
    assign bus.selected = sel;
    assign bus.bitEdge  = rise;
    assign cardToHostLine = dout_reg;

    always_comb begin
        clkLast_next = clkSync_reg[1];
        bitCnt_next  = bitCnt_reg;
        rxSh_next    = rxSh_reg;
        txSh_next    = txSh_reg;
        rxValid_next = 1'b0;
        taken_next   = 1'b0;
        dout_next    = dout_reg;
        if (!sel) begin
            bitCnt_next = 3'h0;
            txSh_next   = 8'hff;
            dout_next   = 1'b1;
        end else begin
            if (rise) begin
                rxSh_next   = {rxSh_reg[6:0], dinSync_reg[1]};
                bitCnt_next = bitCnt_reg + 3'h1;
                if (bitCnt_reg == 3'h7) begin
                    rxValid_next = 1'b1;
                end
            end
            if (fall) begin
                if (bitCnt_reg == 3'h0) begin
                    txSh_next  = {(bus.txLoad ? bus.txByte[6:0] : 7'h7f), 1'b1};
                    dout_next  = bus.txLoad ? bus.txByte[7] : 1'b1;
                    taken_next = 1'b1;
                end else begin
                    dout_next = txSh_reg[7];
                    txSh_next = {txSh_reg[6:0], 1'b1};
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clkSync_reg <= 2'h0;
            selSync_reg <= 2'h3;
            dinSync_reg <= 2'h3;
            clkLast_reg <= 1'b0;
            bitCnt_reg  <= 3'h0;
            rxSh_reg    <= 8'h00;
            txSh_reg    <= 8'hff;
            rxValid_reg <= 1'b0;
            taken_reg   <= 1'b0;
            dout_reg    <= 1'b1;
        end else begin
            clkSync_reg <= {clkSync_reg[0], linkClk};
            selSync_reg <= {selSync_reg[0], selectN};
            dinSync_reg <= {dinSync_reg[0], hostToCardLine};
            clkLast_reg <= clkLast_next;
            bitCnt_reg  <= bitCnt_next;
            rxSh_reg    <= rxSh_next;
            txSh_reg    <= txSh_next;
            rxValid_reg <= rxValid_next;
            taken_reg   <= taken_next;
            dout_reg    <= dout_next;
        end
    end
endmodule
`default_nettype wire

// File: test/cbts_host.sv
// Host model for the serial link: link clock, select and data, mode 0.
// Assumes clk comes from the bench; link clock stands low between bytes.
`timescale 1ns/10ps
`default_nettype none
module cbts_host (
    input  wire logic clk,
    input  wire logic cardToHostLine,
    output var  logic linkClk,
    output var  logic selectN,
    output var  logic hostToCardLine
);
    initial begin
        linkClk = 1'b0;
        selectN = 1'b1;
        hostToCardLine = 1'b1;
    end
    // Select change; on release the data line stops holding its value
    task automatic sel(input logic lvl);
        @(posedge clk);
        selectN <= lvl;
        if (lvl) begin
            hostToCardLine <= ~hostToCardLine;
        end
        repeat (lvl ? 200 : 25) @(posedge clk);
    endtask
    // One byte each way, MSB first, 125 ns per bit
    task automatic xfer(input logic [7:0] o, output logic [7:0] i);
        for (int b = 7; b >= 0; b--) begin
            hostToCardLine <= o[b];
            repeat (12) @(posedge clk);
            linkClk <= 1'b1;
            i[b] = cardToHostLine;
            repeat (13) @(posedge clk);
            linkClk <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// File: test/cbts_card_monitor.sv
// Checker on the card engine's top ports.
// Assumes one clock domain; bound below.
`timescale 1ns/10ps
`default_nettype none
module cbts_card_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic linkClk,
    input wire logic selectN,
    input wire logic cardToHostLine,
    input wire logic serialMode,
    input wire logic programming,
    input wire logic writeStrobe
);
    logic [15:0] progCnt_reg;
    logic [15:0] progCnt_next;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    always_comb progCnt_next = programming ? progCnt_reg + 16'h0001 : 16'h0000;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) progCnt_reg <= 16'h0000;
        else progCnt_reg <= progCnt_next;
    end
    a_mode_kept: assert property (serialMode |=> serialMode)
        else $error("serial mode dropped");
    a_entry_selected: assert property ($rose(serialMode) |-> !selectN)
        else $error("serial mode entered while not selected");
    a_native_silent: assert property (!serialMode |-> cardToHostLine)
        else $error("output driven in native mode");
    a_out_after_fall: assert property (serialMode && $changed(cardToHostLine) |-> !linkClk)
        else $error("output changed while link clock high");
    a_strobe_spaced: assert property (writeStrobe |=> !writeStrobe [*8])
        else $error("write strobes closer than a byte");
    a_strobe_serial: assert property (writeStrobe |-> serialMode && !programming)
        else $error("write strobe outside serial transfer");
    a_prog_bounded: assert property (programming |-> serialMode && progCnt_reg < 16'h0500)
        else $error("programming too long");
    a_prog_full: assert property ($fell(programming) |-> progCnt_reg >= 16'h03f0)
        else $error("programming cut short");
    cover property ($rose(serialMode));
    cover property (writeStrobe);
    cover property ($fell(programming));
endmodule
bind cbts_card cbts_card_monitor cbts_card_monitor_inst (.clk(clk), .rstn(rstn),
    .linkClk(linkClk), .selectN(selectN), .cardToHostLine(cardToHostLine),
    .serialMode(serialMode), .programming(programming), .writeStrobe(writeStrobe));
`default_nettype wire

// File: test/test_card_bus_timing_and_serial_mode.sv
// Bench for the serial card engine: host model, byte queue model, checks.
// Assumes the checker binds itself from its own file.
`timescale 1ns/10ps
`default_nettype none
`include "cbts_defines.svh"
module test_card_bus_timing_and_serial_mode import cbts_pkg::*;;
    logic       clk, rstn, linkClk, selectN, hostToCardLine;
    logic       partialAllowed, retrieveError, cardToHostLine;
    logic       serialMode, programming, writeStrobe;
    logic [7:0] writeByte, rx, r1, wb;
    logic [7:0] wq[$];
    logic [5:0] bad[5] = '{6'h02, 6'h03, 6'h0b, 6'h13, 6'h14};
    int         mismatches, checks_done, cycles;
    cbts_card cbts_card_inst (.clk(clk), .rstn(rstn), .linkClk(linkClk), .selectN(selectN),
        .hostToCardLine(hostToCardLine), .partialAllowed(partialAllowed),
        .retrieveError(retrieveError), .cardToHostLine(cardToHostLine),
        .serialMode(serialMode), .programming(programming),
        .writeStrobe(writeStrobe), .writeByte(writeByte));
    cbts_host cbts_host_inst (.clk(clk), .cardToHostLine(cardToHostLine), .linkClk(linkClk),
        .selectN(selectN), .hostToCardLine(hostToCardLine));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h got %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Command frame, then wait a bounded number of slots for an answer
    task automatic cmd(input logic [5:0] idx, input logic [7:0] crc, output logic [7:0] r);
        cbts_host_inst.xfer({2'b01, idx}, rx);
        repeat (4) cbts_host_inst.xfer(8'h00, rx);
        cbts_host_inst.xfer(crc, rx);
        r = 8'hff;
        for (int n = 0; n < 10 && r == 8'hff; n++) cbts_host_inst.xfer(8'hff, r);
    endtask
    task automatic txn(input logic [5:0] idx, input logic [7:0] crc, input int extra);
        cbts_host_inst.sel(1'b0);
        cmd(idx, crc, r1);
        repeat (extra) cbts_host_inst.xfer(8'hff, rx);
        cbts_host_inst.xfer(8'hff, rx);
        cbts_host_inst.sel(1'b1);
    endtask
    task automatic rd(input logic [5:0] idx, input int len, input logic [7:0] tok);
        txn(idx, 8'h01, -1);
        cbts_host_inst.sel(1'b0);
        cmd(idx, 8'h01, r1);
        check("read status", `CBTS_R1_READY, r1);
        rx = 8'hff;
        for (int n = 0; n < 16 && rx == 8'hff; n++) cbts_host_inst.xfer(8'hff, rx);
        check("data token", tok, rx);
        repeat (tok == `CBTS_TOKEN_START ? len : 0) cbts_host_inst.xfer(8'hff, rx);
        repeat (tok == `CBTS_TOKEN_START ? 2 : 0) begin
            cbts_host_inst.xfer(8'hff, rx);
            check("crc byte", 8'h00, rx);
        end
        cbts_host_inst.xfer(8'hff, rx);
        check("after block", 8'hff, rx);
        cbts_host_inst.sel(1'b1);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (writeStrobe === 1'b1) check("write byte", wq.size() ? wq.pop_front() : 8'hxx, writeByte);
        if (cycles == 95000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        rstn = 1'b0;
        partialAllowed = 1'b0;
        retrieveError = 1'b0;
        void'($urandom(57196));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        retrieveError <= 1'($urandom);
        repeat (8) @(posedge clk);
        txn(`CBTS_CMD_STATUS, 8'h01, 0);
        check("native silent", 8'hff, r1);
        txn(`CBTS_CMD_RESET, 8'h00, 0);
        check("bad crc reset", 8'hff, r1);
        repeat (6) cbts_host_inst.xfer(8'hff, rx);
        check("mode unchosen", 8'h00, {7'h00, serialMode});
        $display("test native done");
        retrieveError <= 1'b0;
        partialAllowed <= 1'($urandom);
        txn(`CBTS_CMD_RESET, 8'h95, 0);
        check("entry reset", `CBTS_R1_IDLE, r1);
        cbts_host_inst.xfer(8'h40, rx);
        repeat (4) cbts_host_inst.xfer(8'h00, rx);
        cbts_host_inst.xfer(8'h95, rx);
        check("mode kept", 8'h01, {7'h00, serialMode});
        $display("test entry done");
        foreach (bad[i]) begin
            txn(bad[i], 8'h01, 0);
            check("refused command", `CBTS_R1_ILLEGAL, r1);
        end
        $display("test refusals done");
        txn(`CBTS_CMD_SEND_OCR, 8'h01, 0);
        check("always answers", 8'h00, {7'h00, r1 == 8'hff});
        rd(`CBTS_CMD_SEND_CID, 16, `CBTS_TOKEN_START);
        rd(`CBTS_CMD_SEND_CSD, 16, `CBTS_TOKEN_START);
        txn(`CBTS_CMD_STATUS, 8'h01, 1);
        check("two byte reply end", 8'hff, rx);
        txn(`CBTS_CMD_READ_OCR, 8'h01, 4);
        check("five byte reply end", 8'hff, rx);
        cbts_host_inst.sel(1'b0);
        cmd(`CBTS_CMD_READ_MULTI, 8'h01, r1);
        rx = 8'hff;
        for (int n = 0; n < 16 && rx == 8'hff; n++) cbts_host_inst.xfer(8'hff, rx);
        check("multi token", `CBTS_TOKEN_START, rx);
        cmd(`CBTS_CMD_STOP, 8'h01, r1);
        check("stop status", `CBTS_R1_READY, r1);
        cbts_host_inst.xfer(8'hff, rx);
        check("data ceased", 8'hff, rx);
        cbts_host_inst.sel(1'b1);
        $display("test registers done");
        retrieveError <= 1'b1;
        rd(`CBTS_CMD_SEND_CID, 16, `CBTS_TOKEN_ERROR);
        retrieveError <= 1'b0;
        $display("test error done");
        partialAllowed <= 1'b1;
        cbts_host_inst.sel(1'b0);
        cmd(`CBTS_CMD_WRITE_ONE, 8'h01, r1);
        check("write status", `CBTS_R1_READY, r1);
        cbts_host_inst.xfer(8'hff, rx);
        cbts_host_inst.xfer(`CBTS_TOKEN_START, rx);
        repeat (16) begin
            wb = 8'($urandom);
            wq.push_back(wb);
            cbts_host_inst.xfer(wb, rx);
        end
        repeat (2) cbts_host_inst.xfer(8'h00, rx);
        rx = 8'hff;
        for (int n = 0; n < 8 && rx == 8'hff; n++) cbts_host_inst.xfer(8'hff, rx);
        check("data response", `CBTS_DATA_ACCEPT, rx);
        cbts_host_inst.sel(1'b1);
        check("busy after release", 8'h01, {7'h00, programming});
        for (int n = 0; n < 2000 && programming !== 1'b0; n++) @(posedge clk);
        check("programming ends", 8'h00, {7'h00, programming});
        check("bytes left", 8'h00, 8'(wq.size()));
        $display("test write done");
        print_verdict();
    end
endmodule
`default_nettype wire
